// File: addr_former.sv
// Purpose: forms the actual and indirect destination addresses
// Assumes: offset and row pointer values come from the register core
// Notes: purely combinational, adds no cycle of its own
`timescale 1ns/1ps
module addr_former
   import addr_mod_pkg::*;
(
   // instruction addresses
   input wire dm_addr_t mem_addr,
   input wire dm_addr_t ind_addr,
   // modifier state
   input wire dm_addr_t offset,
   input wire logic offset_on,
   input wire logic row_ptr_on,
   // formed addresses
   output dm_addr_t mem_addr_mod,
   output dm_addr_t ind_addr_mod
);

   wire [ROW_PTR_W-1:0] row_ptr = offset[DM_ADDR_W-1:DM_ADDR_W-ROW_PTR_W];

   assign mem_addr_mod = offset_on ? (mem_addr | offset) : mem_addr;
   // bank and row swapped for the pointer, column kept
   assign ind_addr_mod = row_ptr_on ? {row_ptr, ind_addr[DM_ADDR_W-ROW_PTR_W-1:0]}
                                    : ind_addr;

endmodule

// File: addr_mod_pkg.sv
// Purpose: shared constants and types of the data memory address modifier
// Assumes: 4-bit system registers at 7-bit addresses, 11-bit data memory address
// Notes: data memory address is {bank[2:0], row[3:0], column[3:0]}
package addr_mod_pkg;

   // system register addresses
   localparam logic [6:0] OFFSET_HIGH_ADDR = 7'h7A;
   localparam logic [6:0] OFFSET_MID_ADDR = 7'h7B;
   localparam logic [6:0] OFFSET_LOW_ADDR = 7'h7C;
   localparam logic [6:0] ROW_PTR_HIGH_ADDR = 7'h7D;
   localparam logic [6:0] ROW_PTR_LOW_ADDR = 7'h7E;
   localparam logic [6:0] FLAG_NIBBLE_ADDR = 7'h7F;

   // field positions inside the nibbles
   localparam int ROW_PTR_EN_BIT = 3;
   localparam int OFFSET_TOP_BIT = 0;
   localparam int WORK_BANK_BIT = 0;
   localparam int BCD_BIT = 0;
   localparam int COMPARE_BIT = 3;
   localparam int CARRY_BIT = 2;
   localparam int ZERO_BIT = 1;
   localparam int OFFSET_EN_BIT = 0;

   // widths
   localparam int DM_ADDR_W = 11;
   localparam int OFFSET_LIVE_W = 9;
   localparam int ROW_PTR_W = 7;

   // reset values
   localparam logic [OFFSET_LIVE_W-1:0] OFFSET_RESET = 9'h000;
   localparam logic [2:0] WORK_ROW_RESET = 3'h0;
   localparam logic NIBBLE_BIT_RESET = 1'b0;
   localparam logic [3:0] READ_ZERO = 4'h0;

   typedef logic [DM_ADDR_W-1:0] dm_addr_t;

   typedef enum logic [2:0] {
      CLS_NONE = 3'b000,
      CLS_MEM = 3'b001,
      CLS_EXEMPT = 3'b010,
      CLS_INDIRECT = 3'b011,
      CLS_OFFSET_INC = 3'b100
   } instr_class_t;

   typedef struct packed {
      logic valid;
      instr_class_t cls;
      dm_addr_t mem_addr;
      dm_addr_t ind_addr;
   } instr_req_t;

   typedef struct packed {
      logic valid;
      dm_addr_t mem_addr;
      dm_addr_t ind_addr;
   } addr_out_t;

   typedef struct packed {
      logic upd_carry;
      logic carry;
      logic upd_zero;
      logic zero;
   } alu_flags_t;

   typedef struct packed {
      logic bcd;
      logic compare;
      logic carry;
      logic zero;
      logic offset_en;
   } status_word_t;

   typedef struct packed {
      logic use_offset;
      logic use_row_ptr;
      logic step_offset;
   } policy_t;

endpackage

// File: addr_mod_properties.sv
// Purpose: port-level checks of the address modifier
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the top module
`timescale 1ns/1ps
module addr_mod_properties
   import addr_mod_pkg::*;
(
   // watched ports
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [6:0] REG_ADDR,
   input wire logic [3:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [3:0] REG_RDATA,
   input wire instr_req_t INSTR,
   input wire alu_flags_t ALU,
   input wire addr_out_t ADDR_OUT,
   input wire logic WORK_BANK,
   input wire logic [2:0] WORK_ROW,
   input wire status_word_t STATUS
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   wire v = INSTR.valid;
   wire mem = v && INSTR.cls == CLS_MEM;
   wire exm = v && INSTR.cls == CLS_EXEMPT;
   wire ind = v && INSTR.cls == CLS_INDIRECT;
   wire wf = REG_WR && REG_ADDR == FLAG_NIBBLE_ADDR;
   ////////////////////////////////////////////////////////////
   a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 4'h0)
      else $error("read data not idle");
   a_answer_next: assert property (v && INSTR.cls != CLS_NONE |=> ADDR_OUT.valid)
      else $error("no address answer");
   a_no_answer: assert property (!v |=> !ADDR_OUT.valid)
      else $error("spurious address answer");
   a_or_keeps: assert property (mem |=> (ADDR_OUT.mem_addr & $past(INSTR.mem_addr)) == $past(INSTR.mem_addr))
      else $error("modified address lost bits");
   a_offset_off: assert property (mem && !STATUS.offset_en |=> ADDR_OUT.mem_addr == $past(INSTR.mem_addr))
      else $error("offset applied while disabled");
   a_exempt_plain: assert property (exm |=> ADDR_OUT.mem_addr == $past(INSTR.mem_addr))
      else $error("exempt address modified");
   a_ind_column: assert property (ind |=> ADDR_OUT.ind_addr[3:0] == $past(INSTR.ind_addr[3:0]))
      else $error("indirect column changed");
   a_rowptr_only: assert property (mem |=> ADDR_OUT.ind_addr == $past(INSTR.ind_addr))
      else $error("row pointer used outside indirect");
   a_flag_write: assert property (wf |=> {STATUS.compare, STATUS.offset_en} == $past({REG_WDATA[3], REG_WDATA[0]}))
      else $error("flag write lost");
   a_alu_carry: assert property (ALU.upd_carry |=> STATUS.carry == $past(ALU.carry))
      else $error("carry update lost");
   a_bank_write: assert property (REG_WR && REG_ADDR == ROW_PTR_HIGH_ADDR |=> WORK_BANK == $past(REG_WDATA[0]))
      else $error("working bank not written");
   a_reset_clear: assert property ($rose(RST_N) |-> STATUS == '0 && WORK_ROW == 3'h0 && !WORK_BANK)
      else $error("state not cleared by reset");
   c_mem_mod: cover property (mem && STATUS.offset_en);
   c_indirect: cover property (ind);
   c_flag_rd: cover property (wf ##1 REG_RD);
endmodule
bind data_memory_address_modifier addr_mod_properties u_props (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .INSTR(INSTR), .ALU(ALU),
   .ADDR_OUT(ADDR_OUT), .WORK_BANK(WORK_BANK), .WORK_ROW(WORK_ROW), .STATUS(STATUS));

// File: data_memory_address_modifier.sv
// Purpose: index/row-pointer address modification, working-row pointer, status word
// Assumes: RST_N is asserted for power-on, clock-stop and chip-enable resets alike
// Notes: instruction answer is registered one clock after the request
//
// How it works
// - actual address is instruction address OR offset
// - offset applied only while offset enable set
// - all data memory instructions take offset modification
// - listed control instructions are exempt from offset
// - indirect transfers swap bank/row for row pointer
// - row pointer substitution only while its enable set
// - row pointer touches only indirect transfer instructions
// - offset increment adds one, wraps 1FFH to 000H
// - working-row pointer from 7DH bit0, 7EH bits3..1
// - upper bit picks bank, lower three bits row
// - 7EH bit0 is decimal flag; software preserves it
// - five flags: decimal, compare, carry, zero, offset enable
// - every reset clears pointer and all flags
// - offset is 9 bits over 7AH..7CH, enable 7FH bit0
// - row pointer is upper offset bits, enable 7AH bit3
// - fixed-zero bits ignore writes and read zero
`timescale 1ns/1ps
module data_memory_address_modifier
   import addr_mod_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // system register port
   input wire logic [6:0] REG_ADDR,
   input wire logic [3:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [3:0] REG_RDATA,
   // instruction request from decoder
   input wire instr_req_t INSTR,
   // flag results from the alu
   input wire alu_flags_t ALU,
   // modified addresses to data memory
   output addr_out_t ADDR_OUT,
   // working register row
   output logic WORK_BANK,
   output logic [2:0] WORK_ROW,
   // status word
   output status_word_t STATUS
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   // offset and row pointer enable
   logic [OFFSET_LIVE_W-1:0] offset_r;
   logic [OFFSET_LIVE_W-1:0] offset_nxt;
   logic row_ptr_en_r;
   logic row_ptr_en_nxt;

   // working-row pointer
   logic work_bank_r;
   logic work_bank_nxt;
   logic [2:0] work_row_r;
   logic [2:0] work_row_nxt;

   // status word flags
   logic bcd_r;
   logic bcd_nxt;
   logic compare_r;
   logic compare_nxt;
   logic carry_r;
   logic carry_nxt;
   logic zero_r;
   logic zero_nxt;
   logic offset_en_r;
   logic offset_en_nxt;

   // bus and instruction answers
   logic [3:0] rdata_r;
   logic [3:0] rdata_nxt;
   addr_out_t addr_out_r;
   addr_out_t addr_out_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // register decode

   // strobe qualified by one nibble address; unmapped addresses match nothing
   function automatic logic strobe_hit(input logic stb, input logic [6:0] a, input logic [6:0] target);
      return stb && (a == target);
   endfunction

   wire wr_ofs_high = strobe_hit(REG_WR, REG_ADDR, OFFSET_HIGH_ADDR);
   wire wr_ofs_mid = strobe_hit(REG_WR, REG_ADDR, OFFSET_MID_ADDR);
   wire wr_ofs_low = strobe_hit(REG_WR, REG_ADDR, OFFSET_LOW_ADDR);
   wire wr_row_high = strobe_hit(REG_WR, REG_ADDR, ROW_PTR_HIGH_ADDR);
   wire wr_row_low = strobe_hit(REG_WR, REG_ADDR, ROW_PTR_LOW_ADDR);
   wire wr_flags = strobe_hit(REG_WR, REG_ADDR, FLAG_NIBBLE_ADDR);

   ////////////////////////////////////////////////////////////////////////////
   // instruction policy and address forming

   policy_t policy;
   dm_addr_t offset_full;
   dm_addr_t mem_addr_mod;
   dm_addr_t ind_addr_mod;

   // class permissions as sorted by the decoder
   instr_policy u_policy (
      .cls(INSTR.cls),
      .policy(policy)
   );

   // upper two offset bits are wired to zero
   assign offset_full = {{(DM_ADDR_W-OFFSET_LIVE_W){1'b0}}, offset_r};

   // gates use flag state of the request edge; a write in the same cycle is not yet seen
   wire offset_on = policy.use_offset && offset_en_r;
   wire row_ptr_on = policy.use_row_ptr && row_ptr_en_r;

   addr_former u_former (
      .mem_addr(INSTR.mem_addr),
      .ind_addr(INSTR.ind_addr),
      .offset(offset_full),
      .offset_on(offset_on),
      .row_ptr_on(row_ptr_on),
      .mem_addr_mod(mem_addr_mod),
      .ind_addr_mod(ind_addr_mod)
   );

   // the increment is an instruction of its own, never an address modifier
   wire step = INSTR.valid && policy.step_offset;
   wire [OFFSET_LIVE_W-1:0] offset_inc = offset_r + 9'h001;

   ////////////////////////////////////////////////////////////////////////////
   // next-state: offset and row pointer

   // only the nine live bits step; the two above them stay tied low
   // a bus write to a nibble overrides the increment in the same cycle
   always_comb begin
      offset_nxt = step ? offset_inc : offset_r;
      if (wr_ofs_high) begin
         offset_nxt[OFFSET_LIVE_W-1] = REG_WDATA[OFFSET_TOP_BIT];
      end
      if (wr_ofs_mid) begin
         offset_nxt[7:4] = REG_WDATA;
      end
      if (wr_ofs_low) begin
         offset_nxt[3:0] = REG_WDATA;
      end
   end

   assign row_ptr_en_nxt = wr_ofs_high ? REG_WDATA[ROW_PTR_EN_BIT] : row_ptr_en_r;

   ////////////////////////////////////////////////////////////////////////////
   // next-state: working-row pointer and status word

   assign work_bank_nxt = wr_row_high ? REG_WDATA[WORK_BANK_BIT] : work_bank_r;
   assign work_row_nxt = wr_row_low ? REG_WDATA[3:1] : work_row_r;
   assign bcd_nxt = wr_row_low ? REG_WDATA[BCD_BIT] : bcd_r;
   assign compare_nxt = wr_flags ? REG_WDATA[COMPARE_BIT] : compare_r;
   assign offset_en_nxt = wr_flags ? REG_WDATA[OFFSET_EN_BIT] : offset_en_r;

   // alu result wins over a bus write in the same cycle
   always_comb begin
      carry_nxt = wr_flags ? REG_WDATA[CARRY_BIT] : carry_r;
      zero_nxt = wr_flags ? REG_WDATA[ZERO_BIT] : zero_r;
      if (ALU.upd_carry) begin
         carry_nxt = ALU.carry;
      end
      if (ALU.upd_zero) begin
         zero_nxt = ALU.zero;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux

   // read view of every nibble, fixed-zero bits tied low
   wire [3:0] view_ofs_high = {row_ptr_en_r, 2'b00, offset_r[OFFSET_LIVE_W-1]};
   wire [3:0] view_ofs_mid = offset_r[7:4];
   wire [3:0] view_ofs_low = offset_r[3:0];
   wire [3:0] view_row_high = {3'b000, work_bank_r};
   wire [3:0] view_row_low = {work_row_r, bcd_r};
   wire [3:0] view_flags = {compare_r, carry_r, zero_r, offset_en_r};

   // nothing but a read strobe puts data on the port
   always_comb begin
      rdata_nxt = READ_ZERO;
      if (REG_RD) begin
         case (REG_ADDR)
            OFFSET_HIGH_ADDR: begin
               rdata_nxt = view_ofs_high;
            end
            OFFSET_MID_ADDR: begin
               rdata_nxt = view_ofs_mid;
            end
            OFFSET_LOW_ADDR: begin
               rdata_nxt = view_ofs_low;
            end
            ROW_PTR_HIGH_ADDR: begin
               rdata_nxt = view_row_high;
            end
            ROW_PTR_LOW_ADDR: begin
               rdata_nxt = view_row_low;
            end
            FLAG_NIBBLE_ADDR: begin
               rdata_nxt = view_flags;
            end
            default: begin
               rdata_nxt = READ_ZERO;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address answer

   // registered answer lands one clock on, inside the multi-clock instruction cycle
   wire answer_valid = INSTR.valid && (INSTR.cls != CLS_NONE);

   always_comb begin
      addr_out_nxt.valid = answer_valid;
      addr_out_nxt.mem_addr = mem_addr_mod;
      addr_out_nxt.ind_addr = ind_addr_mod;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   // the asynchronous clear stands for power-on, clock-stop and chip-enable resets alike
   // offset and row pointer enable
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         offset_r <= OFFSET_RESET;
         row_ptr_en_r <= NIBBLE_BIT_RESET;
      end else begin
         offset_r <= offset_nxt;
         row_ptr_en_r <= row_ptr_en_nxt;
      end
   end

   // working-row pointer
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         work_bank_r <= NIBBLE_BIT_RESET;
         work_row_r <= WORK_ROW_RESET;
      end else begin
         work_bank_r <= work_bank_nxt;
         work_row_r <= work_row_nxt;
      end
   end

   // status word flags
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         bcd_r <= NIBBLE_BIT_RESET;
         compare_r <= NIBBLE_BIT_RESET;
         carry_r <= NIBBLE_BIT_RESET;
         zero_r <= NIBBLE_BIT_RESET;
         offset_en_r <= NIBBLE_BIT_RESET;
      end else begin
         bcd_r <= bcd_nxt;
         compare_r <= compare_nxt;
         carry_r <= carry_nxt;
         zero_r <= zero_nxt;
         offset_en_r <= offset_en_nxt;
      end
   end

   // read nibble, zero whenever no read was taken
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_r <= READ_ZERO;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // address answer
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         addr_out_r <= '0;
      end else begin
         addr_out_r <= addr_out_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // every output comes straight from a register
   assign REG_RDATA = rdata_r;
   assign ADDR_OUT = addr_out_r;
   assign WORK_BANK = work_bank_r;
   assign WORK_ROW = work_row_r;
   assign STATUS = '{bcd: bcd_r, compare: compare_r, carry: carry_r, zero: zero_r,
                     offset_en: offset_en_r};

endmodule

// File: instr_policy.sv
// Purpose: which address modifications an instruction class takes
// Assumes: the decoder has already sorted the opcode into a class
// Notes: purely combinational
`timescale 1ns/1ps
module instr_policy
   import addr_mod_pkg::*;
(
   // decoded instruction
   input wire instr_class_t cls,
   // modification permissions
   output policy_t policy
);

   function automatic policy_t classify(input instr_class_t c);
      policy_t p;
      p = '0;
      case (c)
         CLS_MEM: begin
            p.use_offset = 1'b1;
         end
         CLS_INDIRECT: begin
            p.use_offset = 1'b1;
            p.use_row_ptr = 1'b1;
         end
         CLS_OFFSET_INC: begin
            p.step_offset = 1'b1;
         end
         CLS_EXEMPT: begin
            p = '0;
         end
         default: begin
            p = '0;
         end
      endcase
      return p;
   endfunction

   assign policy = classify(cls);

endmodule

// File: tb.sv
// Purpose: directed test of the address modifier
// Assumes: 200 MHz clock, reset held 10 cycles
// Notes: tasks check half a cycle after the edge that registers the answer
`timescale 1ns/1ps
module tb
   import addr_mod_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [3:0] wdata = 4'h0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [3:0] rdata;
   instr_req_t instr = '0;
   alu_flags_t alu = '0;
   addr_out_t aout;
   logic wbank;
   logic [2:0] wrow;
   status_word_t status;
   int error_cnt = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #2.5 clk = ~clk;
   data_memory_address_modifier uut (.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr_stb), .REG_RD(rd_stb), .REG_RDATA(rdata), .INSTR(instr), .ALU(alu), .ADDR_OUT(aout),
      .WORK_BANK(wbank), .WORK_ROW(wrow), .STATUS(status));
   ////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic put_reg(input logic [6:0] a, input logic [3:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   task automatic get_reg(input logic [6:0] a, input logic [3:0] e);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      chk(11'(rdata), 11'(e), "rdata");
   endtask
   task automatic issue(input instr_class_t c, input dm_addr_t m, input dm_addr_t i,
      input dm_addr_t em, input dm_addr_t ei);
      @(posedge clk);
      instr <= '{1'b1, c, m, i};
      @(posedge clk);
      instr <= '0;
      @(negedge clk);
      chk(11'(aout.valid), 11'(c != CLS_NONE), "valid");
      if (c != CLS_NONE) begin
         chk(aout.mem_addr, em, "mem_addr");
         chk(aout.ind_addr, ei, "ind_addr");
      end
   endtask
   ////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(11'({status, wbank, wrow}), 11'h0, "reset state");
      for (int k = 0; k < 6; k++) begin
         get_reg(OFFSET_HIGH_ADDR + 7'(k), 4'h0);
      end
      put_reg(OFFSET_HIGH_ADDR, 4'hF);
      get_reg(OFFSET_HIGH_ADDR, 4'h9);
      put_reg(ROW_PTR_HIGH_ADDR, 4'hF);
      get_reg(ROW_PTR_HIGH_ADDR, 4'h1);
      put_reg(7'h10, 4'hF);
      get_reg(7'h10, 4'h0);
      put_reg(ROW_PTR_LOW_ADDR, 4'hB);
      @(negedge clk);
      chk(11'({wbank, wrow, status.bcd}), 11'h1B, "work row");
      for (int k = 0; k < 4; k++) begin
         put_reg(FLAG_NIBBLE_ADDR, 4'h1 << k);
         get_reg(FLAG_NIBBLE_ADDR, 4'h1 << k);
         chk(11'(status[3:0]), 11'(4'h1 << k), "flags");
      end
      put_reg(OFFSET_HIGH_ADDR, 4'h1);
      put_reg(OFFSET_MID_ADDR, 4'h2);
      put_reg(OFFSET_LOW_ADDR, 4'h3);
      put_reg(FLAG_NIBBLE_ADDR, 4'h1);
      issue(CLS_MEM, 11'h404, 11'h7FF, 11'h527, 11'h7FF);
      issue(CLS_EXEMPT, 11'h404, 11'h7FF, 11'h404, 11'h7FF);
      issue(CLS_NONE, 11'h404, 11'h7FF, 11'h0, 11'h0);
      issue(CLS_INDIRECT, 11'h404, 11'h7AB, 11'h527, 11'h7AB);
      put_reg(OFFSET_HIGH_ADDR, 4'h9);
      issue(CLS_INDIRECT, 11'h404, 11'h7AB, 11'h527, 11'h12B);
      put_reg(FLAG_NIBBLE_ADDR, 4'h0);
      issue(CLS_MEM, 11'h404, 11'h7AB, 11'h404, 11'h7AB);
      put_reg(OFFSET_MID_ADDR, 4'hF);
      put_reg(OFFSET_LOW_ADDR, 4'hF);
      issue(CLS_OFFSET_INC, 11'h0, 11'h0, 11'h0, 11'h0);
      get_reg(OFFSET_HIGH_ADDR, 4'h8);
      get_reg(OFFSET_MID_ADDR, 4'h0);
      get_reg(OFFSET_LOW_ADDR, 4'h0);
      put_reg(OFFSET_MID_ADDR, 4'hF);
      put_reg(OFFSET_LOW_ADDR, 4'hF);
      issue(CLS_OFFSET_INC, 11'h0, 11'h0, 11'h0, 11'h0);
      get_reg(OFFSET_HIGH_ADDR, 4'h9);
      // alu update beside a flag write
      @(posedge clk);
      addr <= FLAG_NIBBLE_ADDR;
      wdata <= 4'h0;
      wr_stb <= 1'b1;
      alu <= 4'hF;
      @(posedge clk);
      wr_stb <= 1'b0;
      alu <= '0;
      get_reg(FLAG_NIBBLE_ADDR, 4'h6);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(11'({status, wbank, wrow}), 11'h0, "second reset");
      get_reg(OFFSET_HIGH_ADDR, 4'h0);
      tally_and_finish();
   end
endmodule
